/* File: src/tob_map.svh */
`ifndef TOB_MAP_SVH
`define TOB_MAP_SVH
// Register byte addresses
`define TOB_ADDR_MODE 4'h0
`define TOB_ADDR_TUNE 4'h4
`define TOB_ADDR_DBG 4'h8
`define TOB_ADDR_VAR 4'hC
// Mode option fields
`define TOB_B_ACF 7
`define TOB_B_FRQ 5
`define TOB_B_TG3 2
`define TOB_B_TG2 1
`define TOB_B_TG1 0
// Tuning option fields
`define TOB_B_CLR 3
`define TOB_B_AAO 2
`define TOB_B_TGT 1
`define TOB_B_BASE 0
// Debug option field
`define TOB_B_DBG 3
// Reset values; system-use bits stay at factory value
`define TOB_RST_MODE 8'h00
`define TOB_RST_TUNE 8'h00
`define TOB_RST_DBG 8'h00
`define TOB_RST_VAR 3'h5
`define TOB_MASK_TUNE 8'h0F
`define TOB_MASK_DBG 8'h08
`define TOB_MASK_MODE 8'hA7
// Charge transfer rates in kHz
`define TOB_FRQ_SELF_LO 12'h1F4
`define TOB_FRQ_SELF_HI 12'h3E8
`define TOB_FRQ_PROJ_LO 12'h3E8
`define TOB_FRQ_PROJ_HI 12'h7D0
// Tuning figures in counts
`define TOB_TGT_PROX_LO 10'h140
`define TOB_TGT_TCH_LO 10'h0A0
`define TOB_TGT_PROX_HI 10'h280
`define TOB_TGT_TCH_HI 10'h140
`define TOB_BASE_LO 7'h4B
`define TOB_BASE_HI 7'h64
`endif

/* File: src/tob_pkg.sv */
package tob_pkg;
	typedef struct packed {
		logic ac_filter_enable;
		logic [11:0] charge_khz;
		logic autooff_on_prox;
		logic advanced_autooff_en;
		logic [9:0] target_prox;
		logic [9:0] target_touch;
		logic [6:0] tuning_base;
		logic debug_if_enable;
	} tob_cfg_s;
	typedef enum logic [1:0] {
		TOB_IDLE = 2'b00,
		TOB_ACK = 2'b01,
		TOB_DONE = 2'b11
	} tob_bus_e;
endpackage : tob_pkg

/* File: src/tob_decode.sv */
`timescale 1ns/1ps
`include "tob_map.svh"
module tob_decode (
	input wire logic [7:0] mode_opt,
	input wire logic [7:0] tune_opt,
	input wire logic [7:0] dbg_opt,
	input wire logic proj_cap,
	output tob_pkg::tob_cfg_s cfg
);
	always_comb begin
		cfg.ac_filter_enable = mode_opt[`TOB_B_ACF];
		if (proj_cap) begin
			cfg.charge_khz = mode_opt[`TOB_B_FRQ] ? `TOB_FRQ_PROJ_HI : `TOB_FRQ_PROJ_LO;
		end else begin
			cfg.charge_khz = mode_opt[`TOB_B_FRQ] ? `TOB_FRQ_SELF_HI : `TOB_FRQ_SELF_LO;
		end
		cfg.autooff_on_prox = tune_opt[`TOB_B_CLR];
		cfg.advanced_autooff_en = ~tune_opt[`TOB_B_AAO];
		cfg.target_prox = tune_opt[`TOB_B_TGT] ? `TOB_TGT_PROX_HI : `TOB_TGT_PROX_LO;
		cfg.target_touch = tune_opt[`TOB_B_TGT] ? `TOB_TGT_TCH_HI : `TOB_TGT_TCH_LO;
		cfg.tuning_base = tune_opt[`TOB_B_BASE] ? `TOB_BASE_HI : `TOB_BASE_LO;
		cfg.debug_if_enable = dbg_opt[`TOB_B_DBG];
	end
endmodule : tob_decode

/* File: src/tob_chan.sv */
`timescale 1ns/1ps
module tob_chan (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic ce,
	input wire logic touch,
	input wire logic toggle_en,
	output logic touch_out
);
	logic prev_q;
	logic tog_q;
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			prev_q <= 1'b0;
		end else if (ce) begin
			prev_q <= touch;
		end
	end
	// Toggle on each new touch edge, held state otherwise
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			tog_q <= 1'b0;
		end else if (ce) begin
			if (touch && !prev_q) begin
				tog_q <= ~tog_q;
			end
		end
	end
	// Registered so the output is clean for either mode
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			touch_out <= 1'b0;
		end else if (ce) begin
			touch_out <= toggle_en ? (tog_q ^ (touch && !prev_q)) : touch;
		end
	end
endmodule : tob_chan

/* File: src/tob_top.sv */
// Chosen here: register access over Wishbone and the register offsets.
`timescale 1ns/1ps
`include "tob_map.svh"
// Behaviour
// - Top mode bit enables AC filter
// - Frequency bit doubles charge transfer rate
// - Bit 2 makes channel three toggle
// - Bit 1 makes channel two toggle
// - Bit 0 makes channel one toggle
// - Bit 3 picks auto-off clear event
// - Bit 2 low enables advanced auto-off
// - Bit 1 doubles tuning targets
// - Bit 0 selects tuning base 75/100
// - Fifth byte bit 3 enables debug interface
// - Toggle bits apply only in normal variants
module tob_top #(
	parameter int NCH = 3
) (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic ce,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic wb_err_o,
	input wire logic proj_cap,
	input wire logic [NCH-1:0] touch_in,
	input wire logic touch_event,
	input wire logic prox_event,
	output logic [NCH-1:0] touch_out,
	output logic autooff_restart,
	output tob_pkg::tob_cfg_s cfg_q
);
	logic [7:0] mode_q;
	logic [7:0] tune_q;
	logic [7:0] dbg_q;
	logic [2:0] variant_q;
	logic ack_q;
	logic err_q;
	tob_pkg::tob_bus_e bus_q;
	tob_pkg::tob_cfg_s cfg_d;
	logic normal_var;
	logic [NCH-1:0] tog_en;
	logic req;
	logic wr_en;
	logic wr_mode;
	logic wr_tune;
	logic wr_dbg;
	logic wr_var;
	logic [NCH-1:0] touch_prev_q;

	function automatic logic hit(input logic [3:0] a, input logic [3:0] b);
		return a == b;
	endfunction : hit

	function automatic logic mapped(input logic [3:0] a);
		return hit(a, `TOB_ADDR_MODE) || hit(a, `TOB_ADDR_TUNE) ||
			hit(a, `TOB_ADDR_DBG) || hit(a, `TOB_ADDR_VAR);
	endfunction : mapped

	assign req = wb_cyc_i && wb_stb_i && (bus_q == tob_pkg::TOB_IDLE);
	assign wr_en = ce && req && wb_we_i && wb_sel_i[0];
	assign wr_mode = wr_en && hit(wb_adr_i, `TOB_ADDR_MODE);
	assign wr_tune = wr_en && hit(wb_adr_i, `TOB_ADDR_TUNE);
	assign wr_dbg = wr_en && hit(wb_adr_i, `TOB_ADDR_DBG);
	assign wr_var = wr_en && hit(wb_adr_i, `TOB_ADDR_VAR);

	// One-cycle answer, then one idle cycle before the next
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			bus_q <= tob_pkg::TOB_IDLE;
		end else if (ce) begin
			case (bus_q)
				tob_pkg::TOB_IDLE: begin
					if (req) begin
						bus_q <= tob_pkg::TOB_ACK;
					end
				end
				tob_pkg::TOB_ACK: bus_q <= tob_pkg::TOB_DONE;
				tob_pkg::TOB_DONE: bus_q <= tob_pkg::TOB_IDLE;
				default: bus_q <= tob_pkg::TOB_IDLE;
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			ack_q <= 1'b0;
		end else if (ce) begin
			ack_q <= req && mapped(wb_adr_i);
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			err_q <= 1'b0;
		end else if (ce) begin
			err_q <= req && !mapped(wb_adr_i);
		end
	end
	assign wb_ack_o = ack_q;
	assign wb_err_o = err_q;

	// System-use bits are write-protected so factory values survive
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			mode_q <= `TOB_RST_MODE;
		end else if (wr_mode) begin
			mode_q <= wb_dat_i[7:0] & `TOB_MASK_MODE;
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			tune_q <= `TOB_RST_TUNE;
		end else if (wr_tune) begin
			tune_q <= (tune_q & ~`TOB_MASK_TUNE) | (wb_dat_i[7:0] & `TOB_MASK_TUNE);
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			dbg_q <= `TOB_RST_DBG;
		end else if (wr_dbg) begin
			dbg_q <= (dbg_q & ~`TOB_MASK_DBG) | (wb_dat_i[7:0] & `TOB_MASK_DBG);
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			variant_q <= `TOB_RST_VAR;
		end else if (wr_var) begin
			variant_q <= wb_dat_i[2:0];
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			wb_dat_o <= 32'h00000000;
		end else if (ce && req && !wb_we_i) begin
			if (hit(wb_adr_i, `TOB_ADDR_MODE)) begin
				wb_dat_o <= {24'h000000, mode_q};
			end else if (hit(wb_adr_i, `TOB_ADDR_TUNE)) begin
				wb_dat_o <= {24'h000000, tune_q};
			end else if (hit(wb_adr_i, `TOB_ADDR_DBG)) begin
				wb_dat_o <= {24'h000000, dbg_q};
			end else if (hit(wb_adr_i, `TOB_ADDR_VAR)) begin
				wb_dat_o <= {normal_var, 28'h0000000, variant_q};
			end else begin
				wb_dat_o <= 32'h00000000;
			end
		end
	end

	// Variants 100 and 101 are the normal touch layouts
	assign normal_var = (variant_q == 3'h4) || (variant_q == 3'h5);

	tob_decode u_dec (
		.mode_opt(mode_q),
		.tune_opt(tune_q),
		.dbg_opt(dbg_q),
		.proj_cap(proj_cap),
		.cfg(cfg_d)
	);

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			cfg_q <= '0;
		end else if (ce) begin
			cfg_q <= cfg_d;
		end
	end

	assign tog_en = normal_var ? mode_q[NCH-1:0] : '0;

	// Mirror of the lanes' edge register, kept only for the checks below
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			touch_prev_q <= '0;
		end else if (ce) begin
			touch_prev_q <= touch_in;
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < NCH; gi++) begin : g_ch
			tob_chan u_ch (
				.sys_clk(sys_clk),
				.rstn(rstn),
				.ce(ce),
				.touch(touch_in[gi]),
				.toggle_en(tog_en[gi]),
				.touch_out(touch_out[gi])
			);
			// Assumes toggle mode is enabled while the lane is released
			tog_flip_a: assert property (@(posedge sys_clk) disable iff (!rstn)
				ce && tog_en[gi] && touch_in[gi] && !touch_prev_q[gi]
				|=> touch_out[gi] != $past(touch_out[gi]))
				else $error("toggle flip");
			tog_hold_a: assert property (@(posedge sys_clk) disable iff (!rstn)
				ce && tog_en[gi] && !(touch_in[gi] && !touch_prev_q[gi])
				|=> touch_out[gi] == $past(touch_out[gi]))
				else $error("toggle hold");
			lane_follow_a: assert property (@(posedge sys_clk) disable iff (!rstn)
				ce && !tog_en[gi]
				|=> touch_out[gi] == $past(touch_in[gi]))
				else $error("lane follow");
		end
	endgenerate

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			autooff_restart <= 1'b0;
		end else if (ce) begin
			autooff_restart <= tune_q[`TOB_B_CLR] ? prox_event : touch_event;
		end
	end

	// Bus answer and spacing
	ack_one_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		ce && req && mapped(wb_adr_i)
		|=> wb_ack_o && !wb_err_o)
		else $error("ack missing");
	ack_drop_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		ce && wb_ack_o
		|=> !wb_ack_o)
		else $error("ack held");
	err_map_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		ce && req && !mapped(wb_adr_i)
		|=> wb_err_o)
		else $error("no err");
	err_drop_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		ce && wb_err_o
		|=> !wb_err_o)
		else $error("err held");
	resp_gap_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		ce && (wb_ack_o || wb_err_o)
		|=> !req)
		else $error("request taken too soon");
	no_req_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		ce && !req
		|=> !wb_ack_o && !wb_err_o)
		else $error("answer without request");
	freeze_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		!ce
		|=> $stable(cfg_q) && $stable(touch_out) && $stable(autooff_restart) && $stable(bus_q))
		else $error("state moved while frozen");

	// Register reads and writes
	rd_mode_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		ce && req && !wb_we_i && hit(wb_adr_i, `TOB_ADDR_MODE)
		|=> wb_dat_o == {24'h000000, $past(mode_q)})
		else $error("mode read");
	rd_tune_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		ce && req && !wb_we_i && hit(wb_adr_i, `TOB_ADDR_TUNE)
		|=> wb_dat_o == {24'h000000, $past(tune_q)})
		else $error("tuning read");
	rd_dbg_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		ce && req && !wb_we_i && hit(wb_adr_i, `TOB_ADDR_DBG)
		|=> wb_dat_o == {24'h000000, $past(dbg_q)})
		else $error("debug read");
	rd_var_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		ce && req && !wb_we_i && hit(wb_adr_i, `TOB_ADDR_VAR)
		|=> wb_dat_o[2:0] == $past(variant_q) && wb_dat_o[31] == $past(normal_var))
		else $error("variant read");
	wr_mode_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		wr_mode
		|=> mode_q == ($past(wb_dat_i[7:0]) & `TOB_MASK_MODE))
		else $error("mode write");
	wr_tune_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		wr_tune
		|=> tune_q[3:0] == $past(wb_dat_i[3:0]) && tune_q[7:4] == $past(tune_q[7:4]))
		else $error("tuning write");
	wr_dbg_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		wr_dbg
		|=> dbg_q[`TOB_B_DBG] == $past(wb_dat_i[`TOB_B_DBG]) && dbg_q[7:4] == $past(dbg_q[7:4]))
		else $error("debug write");
	wr_var_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		wr_var
		|=> variant_q == $past(wb_dat_i[2:0]))
		else $error("variant write");
	err_nowr_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		ce && req && wb_we_i && !mapped(wb_adr_i)
		|=> $stable(mode_q) && $stable(tune_q) && $stable(dbg_q) && $stable(variant_q))
		else $error("write to unmapped address");
	sel_nowr_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		ce && req && wb_we_i && !wb_sel_i[0]
		|=> $stable(mode_q) && $stable(tune_q) && $stable(dbg_q) && $stable(variant_q))
		else $error("write without lane select");

	// Decoded options
	acf_cfg_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		ce && $past(ce)
		|-> cfg_q.ac_filter_enable == $past(mode_q[`TOB_B_ACF]))
		else $error("ac filter");
	frq_cfg_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		ce && !proj_cap && mode_q[`TOB_B_FRQ] ##1 ce
		|-> cfg_q.charge_khz == `TOB_FRQ_SELF_HI)
		else $error("rate");
	frq_proj_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		ce && proj_cap && mode_q[`TOB_B_FRQ] ##1 ce
		|-> cfg_q.charge_khz == `TOB_FRQ_PROJ_HI)
		else $error("projected rate");
	frq_lo_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		ce && !proj_cap && !mode_q[`TOB_B_FRQ] ##1 ce
		|-> cfg_q.charge_khz == `TOB_FRQ_SELF_LO)
		else $error("low rate");
	frq_plo_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		ce && proj_cap && !mode_q[`TOB_B_FRQ] ##1 ce
		|-> cfg_q.charge_khz == `TOB_FRQ_PROJ_LO)
		else $error("projected low rate");
	aao_cfg_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		ce ##1 ce
		|-> cfg_q.advanced_autooff_en != $past(tune_q[`TOB_B_AAO]))
		else $error("auto-off polarity");
	tgt_cfg_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		ce && tune_q[`TOB_B_TGT] ##1 ce
		|-> cfg_q.target_prox == `TOB_TGT_PROX_HI && cfg_q.target_touch == `TOB_TGT_TCH_HI)
		else $error("target");
	tgt_lo_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		ce && !tune_q[`TOB_B_TGT] ##1 ce
		|-> cfg_q.target_prox == `TOB_TGT_PROX_LO && cfg_q.target_touch == `TOB_TGT_TCH_LO)
		else $error("low target");
	base_cfg_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		ce && !tune_q[`TOB_B_BASE] ##1 ce
		|-> cfg_q.tuning_base == `TOB_BASE_LO)
		else $error("base");
	base_hi_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		ce && tune_q[`TOB_B_BASE] ##1 ce
		|-> cfg_q.tuning_base == `TOB_BASE_HI)
		else $error("high base");
	dbg_cfg_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		ce && dbg_q[`TOB_B_DBG] ##1 ce
		|-> cfg_q.debug_if_enable)
		else $error("debug");
	dbg_off_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		ce && !dbg_q[`TOB_B_DBG] ##1 ce
		|-> !cfg_q.debug_if_enable)
		else $error("debug off");

	// Auto-off restart source and lane behaviour
	clr_src_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		ce && tune_q[`TOB_B_CLR] && prox_event
		|=> autooff_restart)
		else $error("clear source");
	clr_mask_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		ce && tune_q[`TOB_B_CLR] && !prox_event
		|=> !autooff_restart)
		else $error("clear masked");
	clr_touch_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		ce && !tune_q[`TOB_B_CLR]
		|=> autooff_restart == $past(touch_event))
		else $error("touch clear source");
	follow_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		ce && !normal_var
		|=> touch_out[0] == $past(touch_in[0]))
		else $error("follow");
endmodule : tob_top

/* File: tb/tob_top_tb.sv */
`timescale 1ns/1ps
module tob_top_tb;
	logic sys_clk = 1'b0;
	logic rstn = 1'b0;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [3:0] adr = 4'h0;
	logic [31:0] dat = 32'h0;
	logic proj_cap = 1'b0;
	logic ce = 1'b1;
	logic [3:0] sel = 4'hF;
	logic tev = 1'b0;
	logic pev = 1'b0;
	logic [2:0] touch_in = 3'h0;
	logic [31:0] rdat;
	logic ack;
	logic err;
	logic [2:0] touch_out;
	logic restart;
	logic [31:0] r;
	logic e;
	tob_pkg::tob_cfg_s cfg_q;
	int mismatches = 0;
	int n_compared = 0;
	int cycles = 0;

	tob_top #(.NCH(3)) dut_u (
		.sys_clk(sys_clk), .rstn(rstn), .ce(ce),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.wb_err_o(err), .proj_cap(proj_cap), .touch_in(touch_in),
		.touch_event(tev), .prox_event(pev), .touch_out(touch_out),
		.autooff_restart(restart), .cfg_q(cfg_q)
	);

	always #2 sys_clk = ~sys_clk;

	// Whole run needs a few hundred cycles at most
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			complete_run();
		end
	end

	task automatic complete_run;
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : complete_run

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			$display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
			mismatches++;
		end
	endtask : check

	task automatic sc(input int n);
		repeat (n) @(posedge sys_clk);
	endtask : sc

	// Request held until ack or err is seen at a rising edge
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge sys_clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		do begin
			@(posedge sys_clk);
			n++;
		end while (ack !== 1'b1 && err !== 1'b1 && n < 40);
		if (n >= 40) begin
			mismatches++;
			complete_run();
		end
		r = rdat;
		e = err;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		@(posedge sys_clk);
	endtask : bus

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		bus(1'b1, a, {24'h0, d});
		check({31'h0, e}, 32'h0);
		sc(2);
	endtask : wr

	task automatic rd(input logic [3:0] a, input logic [31:0] x);
		bus(1'b0, a, 32'h0);
		check(r, x);
	endtask : rd

	task automatic do_reset;
		rstn <= 1'b0;
		sc(6);
		rstn <= 1'b1;
		sc(2);
	endtask : do_reset

	// Press, release, press again: toggled lanes flip, the rest follow
	task automatic press(input logic [2:0] tg);
		touch_in <= 3'h7;
		sc(3);
		touch_in <= 3'h0;
		sc(3);
		check({29'h0, touch_out}, {29'h0, tg});
		touch_in <= 3'h7;
		sc(3);
		check({29'h0, touch_out}, {29'h0, 3'h7 ^ tg});
		touch_in <= 3'h0;
		sc(3);
	endtask : press

	initial begin
		do_reset();
		rd(4'h0, 32'h0);
		rd(4'h4, 32'h0);
		rd(4'h8, 32'h0);
		rd(4'hC, 32'h8000_0005);
		check(32'(cfg_q.charge_khz), 32'h1F4);
		check(32'(cfg_q.target_prox), 32'h140);
		check(32'(cfg_q.target_touch), 32'hA0);
		check(32'(cfg_q.tuning_base), 32'h4B);
		check(32'(cfg_q.advanced_autooff_en), 32'h1);
		wr(4'h0, 8'hFF);
		rd(4'h0, 32'hA7);
		check(32'(cfg_q.ac_filter_enable), 32'h1);
		check(32'(cfg_q.charge_khz), 32'h3E8);
		proj_cap <= 1'b1;
		sc(3);
		check(32'(cfg_q.charge_khz), 32'h7D0);
		wr(4'h0, 8'h00);
		check(32'(cfg_q.charge_khz), 32'h3E8);
		check(32'(cfg_q.ac_filter_enable), 32'h0);
		proj_cap <= 1'b0;
		wr(4'h4, 8'hFF);
		rd(4'h4, 32'h0F);
		check(32'(cfg_q.advanced_autooff_en), 32'h0);
		check(32'(cfg_q.target_prox), 32'h280);
		check(32'(cfg_q.target_touch), 32'h140);
		check(32'(cfg_q.tuning_base), 32'h64);
		check(32'(cfg_q.autooff_on_prox), 32'h1);
		wr(4'h8, 8'hFF);
		rd(4'h8, 32'h08);
		check(32'(cfg_q.debug_if_enable), 32'h1);
		wr(4'h8, 8'h00);
		check(32'(cfg_q.debug_if_enable), 32'h0);
		// Lane 0 not selected: the write must not land
		sel <= 4'h0;
		wr(4'h8, 8'hFF);
		rd(4'h8, 32'h0);
		check(32'(cfg_q.debug_if_enable), 32'h0);
		sel <= 4'hF;
		// Unaligned byte address decodes to nothing
		bus(1'b1, 4'h2, 32'hFF);
		check({31'h0, e}, 32'h1);
		pev <= 1'b1;
		sc(3);
		check({31'h0, restart}, 32'h1);
		pev <= 1'b0;
		tev <= 1'b1;
		sc(3);
		check({31'h0, restart}, 32'h0);
		wr(4'h4, 8'h00);
		check({31'h0, restart}, 32'h1);
		tev <= 1'b0;
		pev <= 1'b1;
		sc(3);
		check({31'h0, restart}, 32'h0);
		pev <= 1'b0;
		for (int i = 0; i < 3; i++) begin
			do_reset();
			wr(4'h0, 8'(1 << i));
			press(3'(1 << i));
		end
		// Swipe variant must ignore the toggle bits
		do_reset();
		wr(4'hC, 8'h00);
		rd(4'hC, 32'h0);
		wr(4'h0, 8'h07);
		press(3'h0);
		// Clock enable low freezes the lanes
		ce <= 1'b0;
		touch_in <= 3'h7;
		sc(3);
		check({29'h0, touch_out}, 32'h0);
		ce <= 1'b1;
		sc(3);
		check({29'h0, touch_out}, 32'h7);
		touch_in <= 3'h0;
		sc(3);
		complete_run();
	end
endmodule : tob_top_tb
